// ==== hdl/nand_host_pkg.sv ====
// Shared constants, timing and pin carrier for the NAND flash host controller
package nand_host_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets on the Avalon-MM slave)
  // ----------------------------------------------------------------
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_CMD = 5'h04;
  localparam logic [4:0] OFF_COL = 5'h08;
  localparam logic [4:0] OFF_ROW = 5'h0C;
  localparam logic [4:0] OFF_ADDR = 5'h10;
  localparam logic [4:0] OFF_DATA = 5'h14;
  localparam logic [4:0] OFF_STATUS = 5'h18;
  localparam logic [4:0] OFF_FINISH = 5'h1C;

  // Field positions
  localparam int CTRL_WP_BIT = 0;
  localparam int CTRL_DESEL_BIT = 1;
  localparam int CMD_WAIT_BIT = 8;
  localparam int ADDR_COLONLY_BIT = 0;
  localparam int STS_READY_BIT = 0;
  localparam int STS_ERR_BIT = 1;
  localparam int STS_ENGINE_BIT = 2;
  localparam int STS_BYTE_LSB = 8;
  localparam int DEV_READY_BIT = 6;

  // Reset values: write protect asserted, chip deselected
  localparam logic [1:0] CTRL_RESET = 2'h2;
  localparam logic [12:0] COL_RESET = 13'h0000;
  localparam logic [17:0] ROW_RESET = 18'h00000;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int COL_W = 13;
  localparam int ROW_W = 18;
  localparam int PAGE_W = 6;
  localparam int BLOCK_W = 12;
  localparam logic [12:0] COL_LAST = 13'h10FF;
  localparam int ADDR_CYCLES = 5;
  localparam int COL_CYCLES = 2;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_GO = 8'h30;
  localparam logic [7:0] CMD_OUT_COL = 8'h05;
  localparam logic [7:0] CMD_OUT_COL_GO = 8'hE0;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
  localparam logic [7:0] CMD_PROG_GO = 8'h10;
  localparam logic [7:0] CMD_PROG_CACHE = 8'h15;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_STATUS_MULTI = 8'h71;
  localparam logic [7:0] CMD_RESET = 8'hFF;

  // ----------------------------------------------------------------
  // Timing, in picoseconds, and cycle counts at 200 MHz
  // ----------------------------------------------------------------
  localparam int T_CLK_PS = 5000;
  localparam int T_SETUP_PS = 12000;
  localparam int T_WP_PS = 12000;
  localparam int T_WH_PS = 10000;
  localparam int T_REA_PS = 20000;
  localparam int T_REH_PS = 10000;
  localparam int T_WHR_PS = 60000;
  localparam int T_WB_PS = 100000;
  localparam int SYNC_STAGES = 2;

  // Least time rounded up to whole cycles, never below one
  function automatic int cyc_min(input int ps);
    int c;
    c = (ps + T_CLK_PS - 1) / T_CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_min

  localparam int CYC_SETUP = cyc_min(T_SETUP_PS);
  localparam int CYC_WP = cyc_min(T_WP_PS);
  localparam int CYC_WH = cyc_min(T_WH_PS);
  localparam int CYC_RD_LOW = cyc_min(T_REA_PS) + SYNC_STAGES + 1;
  localparam int CYC_REH = cyc_min(T_REH_PS);
  localparam int CYC_GAP = cyc_min(T_WHR_PS);
  localparam int CYC_WB = cyc_min(T_WB_PS);

  // Pins toward the flash; io_in and busy_flag_n come back separately
  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic output_strobe_n;
    logic wp_n;
    logic io_oe;
    logic [7:0] io_out;
  } pins_t;

endpackage : nand_host_pkg

// ==== hdl/nand_sync.sv ====
// Two-flop synchroniser for pins coming from the flash
`timescale 1ns/1ps
module nand_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : nand_sync

// ==== hdl/nand_strobe.sv ====
// Timed low-then-high strobe pulse generator for write and read strobes
`timescale 1ns/1ps
module nand_strobe (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [7:0] low_cnt,
  input wire logic [7:0] high_cnt,
  output logic strobe_n,
  output logic sample,
  output logic done
);

  logic act_q, act_d;
  logic low_q, low_d;
  logic [7:0] cnt_q, cnt_d;
  logic strobe_n_d;

  // Low phase of low_cnt cycles, then high phase of high_cnt cycles
  always_comb begin
    act_d = act_q;
    low_d = low_q;
    cnt_d = cnt_q;
    strobe_n_d = strobe_n;
    if (start) begin
      act_d = 1'b1;
      low_d = 1'b1;
      cnt_d = low_cnt - 8'h01;
      strobe_n_d = 1'b0;
    end else if (act_q) begin
      if (cnt_q != 8'h00) begin
        cnt_d = cnt_q - 8'h01;
      end else if (low_q) begin
        low_d = 1'b0;
        cnt_d = high_cnt - 8'h01;
        strobe_n_d = 1'b1;
      end else begin
        act_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      act_q <= 1'b0;
      low_q <= 1'b0;
      cnt_q <= 8'h00;
      strobe_n <= 1'b1;
    end else begin
      act_q <= act_d;
      low_q <= low_d;
      cnt_q <= cnt_d;
      strobe_n <= strobe_n_d;
    end
  end

  // Sample on the last low cycle, done on the last high cycle
  assign sample = act_q & low_q & (cnt_q == 8'h00);
  assign done = act_q & ~low_q & (cnt_q == 8'h00);

endmodule : nand_strobe

// ==== hdl/nand_host.sv ====
// Host controller driving the NAND flash pins from Avalon-MM registers
//
// Contract
// - Host sends five address bytes in order, two for a column change
// - Cycle type decoded from latch enable levels
// - Only status, reset and finish reach the pins while device is busy
// - End cache program via status poll, reset
// - End cached multi-page program likewise
// - Host never drives while device drives
`timescale 1ns/1ps
module nand_host (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output nand_host_pkg::pins_t pins,
  input wire logic [7:0] io_in,
  input wire logic busy_flag_n
);

  // ----------------------------------------------------------------
  // Types and helpers
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_SETUP = 7'b0000010,
    S_PULSE = 7'b0000100,
    S_GAP = 7'b0001000,
    S_WB = 7'b0010000,
    S_WAIT = 7'b0100000,
    S_DONE = 7'b1000000
  } state_t;

  typedef enum logic [3:0] {
    K_CMD = 4'b0001,
    K_ADDR = 4'b0010,
    K_DIN = 4'b0100,
    K_DOUT = 4'b1000
  } kind_t;

  typedef enum logic [4:0] {
    OP_CMD = 5'b00001,
    OP_ADDR = 5'b00010,
    OP_DIN = 5'b00100,
    OP_DOUT = 5'b01000,
    OP_FIN = 5'b10000
  } op_t;

  // Byte-lane merge of a bus write into a register word
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction : be_merge

  // Address byte for cycle idx: column low, column high, then three row bytes
  function automatic logic [7:0] addr_byte(input logic [12:0] col, input logic [17:0] row,
                                           input logic [2:0] idx);
    logic [7:0] b;
    unique case (idx)
      3'h0: b = col[7:0];
      3'h1: b = {3'h0, col[12:8]};
      3'h2: b = row[7:0];
      3'h3: b = row[15:8];
      default: b = {6'h00, row[17:16]};
    endcase
    return b;
  endfunction : addr_byte

  // ----------------------------------------------------------------
  // Synchronised pins and strobe engine
  // ----------------------------------------------------------------
  logic [8:0] sync_q;
  logic rdy;
  logic [7:0] io_s;
  logic stb_start, stb_n, stb_sample, stb_done;
  logic [7:0] stb_low, stb_high;

  nand_sync #(.W(9)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({busy_flag_n, io_in}),
    .q(sync_q)
  );
  assign rdy = sync_q[8];
  assign io_s = sync_q[7:0];

  nand_strobe u_strobe (
    .clk(clk),
    .rst_n(rst_n),
    .start(stb_start),
    .low_cnt(stb_low),
    .high_cnt(stb_high),
    .strobe_n(stb_n),
    .sample(stb_sample),
    .done(stb_done)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  state_t state_q, state_d;
  kind_t kind_q, kind_d;
  op_t op_q, op_d;
  logic [7:0] byte_q, byte_d;
  logic [7:0] cnt_q, cnt_d;
  logic [2:0] idx_q, idx_d;
  logic [2:0] last_q, last_d;
  logic [1:0] step_q, step_d;
  logic wait_q, wait_d;
  logic [1:0] ctrl_q, ctrl_d;
  logic [12:0] col_q, col_d;
  logic [17:0] row_q, row_d;
  logic [7:0] cmd_q, cmd_d;
  logic [7:0] data_q, data_d;
  logic err_q, err_d;
  logic [31:0] m;

  // Bus decode
  logic req, sel_cmd, sel_addr, sel_data, sel_fin, is_op, busy_ok, refuse, ack;
  assign req = avs_read | avs_write;
  assign sel_cmd = avs_write & ({avs_address[4:2], 2'b00} == nand_host_pkg::OFF_CMD);
  assign sel_addr = avs_write & ({avs_address[4:2], 2'b00} == nand_host_pkg::OFF_ADDR);
  assign sel_data = req & ({avs_address[4:2], 2'b00} == nand_host_pkg::OFF_DATA);
  assign sel_fin = avs_write & ({avs_address[4:2], 2'b00} == nand_host_pkg::OFF_FINISH);
  assign is_op = sel_cmd | sel_addr | sel_data | sel_fin;

  // While busy only status reads, reset and finish reach the pins
  assign busy_ok = (sel_cmd & ((avs_writedata[7:0] == nand_host_pkg::CMD_STATUS) |
                   (avs_writedata[7:0] == nand_host_pkg::CMD_STATUS_MULTI) |
                   (avs_writedata[7:0] == nand_host_pkg::CMD_RESET))) | sel_fin;

  // Refused ops complete at once and set the error flag
  assign refuse = is_op & ((~rdy & ~busy_ok) |
                  (sel_data & avs_write & ~ctrl_q[nand_host_pkg::CTRL_WP_BIT]) |
                  (sel_data & (col_q > nand_host_pkg::COL_LAST)));

  assign ack = req & (~is_op | (state_q == S_IDLE & refuse) | (state_q == S_DONE));
  assign avs_waitrequest = req & ~ack;

  // ----------------------------------------------------------------
  // Sequencer and register next-state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    kind_d = kind_q;
    op_d = op_q;
    byte_d = byte_q;
    cnt_d = cnt_q;
    idx_d = idx_q;
    last_d = last_q;
    step_d = step_q;
    wait_d = wait_q;
    ctrl_d = ctrl_q;
    col_d = col_q;
    row_d = row_q;
    cmd_d = cmd_q;
    data_d = data_q;
    err_d = err_q;
    stb_start = 1'b0;
    m = 32'h0000_0000;
    unique case (state_q)
      S_IDLE: begin
        if (is_op & ~refuse) begin
          state_d = S_SETUP;
          cnt_d = 8'(nand_host_pkg::CYC_SETUP);
          idx_d = 3'h0;
          step_d = 2'h0;
          wait_d = 1'b0;
          if (sel_cmd) begin
            op_d = OP_CMD;
            kind_d = K_CMD;
            byte_d = avs_writedata[7:0];
            wait_d = avs_writedata[nand_host_pkg::CMD_WAIT_BIT];
          end else if (sel_addr) begin
            op_d = OP_ADDR;
            kind_d = K_ADDR;
            byte_d = addr_byte(col_q, row_q, 3'h0);
            // Two cycles for column change, otherwise the full five
            last_d = avs_writedata[nand_host_pkg::ADDR_COLONLY_BIT] ?
                     3'(nand_host_pkg::COL_CYCLES - 1) :
                     3'(nand_host_pkg::ADDR_CYCLES - 1);
          end else if (sel_fin) begin
            op_d = OP_FIN;
            kind_d = K_CMD;
            byte_d = nand_host_pkg::CMD_STATUS;
          end else if (avs_write) begin
            op_d = OP_DIN;
            kind_d = K_DIN;
            byte_d = avs_writedata[7:0];
          end else begin
            op_d = OP_DOUT;
            kind_d = K_DOUT;
          end
        end
      end
      S_SETUP: begin
        // Latch levels and data settle before the strobe falls
        if (cnt_q == 8'h01) begin
          state_d = S_PULSE;
          stb_start = 1'b1;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      S_PULSE: begin
        if (stb_sample & (kind_q == K_DOUT)) data_d = io_s;
        if (stb_done) begin
          state_d = S_GAP;
          cnt_d = 8'(nand_host_pkg::CYC_GAP);
          if (kind_q == K_CMD) cmd_d = byte_q;
          // Host column mirror follows the device's counter
          if ((kind_q == K_DIN) | (op_q == OP_DOUT)) col_d = col_q + 13'h0001;
        end
      end
      S_GAP: begin
        // Turnaround gap also keeps the bus idle after the device drove it
        if (cnt_q != 8'h01) begin
          cnt_d = cnt_q - 8'h01;
        end else begin
          state_d = S_DONE;
          cnt_d = 8'(nand_host_pkg::CYC_SETUP);
          unique case (op_q)
            OP_ADDR: begin
              if (idx_q != last_q) begin
                state_d = S_SETUP;
                idx_d = idx_q + 3'h1;
                byte_d = addr_byte(col_q, row_q, idx_q + 3'h1);
              end
            end
            OP_CMD: begin
              if (wait_q) begin
                state_d = S_WB;
                cnt_d = 8'(nand_host_pkg::CYC_WB);
              end
            end
            OP_FIN: begin
              unique case (step_q)
                2'h0: begin
                  state_d = S_SETUP;
                  kind_d = K_DOUT;
                  step_d = 2'h1;
                end
                2'h1: begin
                  state_d = S_SETUP;
                  // Poll status until the prior program is done, then reset
                  if (data_q[nand_host_pkg::DEV_READY_BIT]) begin
                    kind_d = K_CMD;
                    byte_d = nand_host_pkg::CMD_RESET;
                    step_d = 2'h2;
                  end
                end
                default: begin
                  state_d = S_WB;
                  cnt_d = 8'(nand_host_pkg::CYC_WB);
                end
              endcase
            end
            default: begin
            end
          endcase
        end
      end
      S_WB: begin
        // Busy line is not valid until the device has had time to pull it
        if (cnt_q != 8'h01) cnt_d = cnt_q - 8'h01;
        else state_d = S_WAIT;
      end
      S_WAIT: begin
        // No fixed busy time is assumed, cached programs vary widely
        if (rdy) state_d = S_DONE;
      end
      S_DONE: begin
        if (req) state_d = S_IDLE;
      end
      default: state_d = S_IDLE;
    endcase

    // Plain register writes take effect on acceptance
    if (avs_write & ack) begin
      unique case ({avs_address[4:2], 2'b00})
        nand_host_pkg::OFF_CTRL: begin
          m = be_merge({30'h0, ctrl_q}, avs_writedata, avs_byteenable);
          ctrl_d = m[1:0];
        end
        nand_host_pkg::OFF_COL: begin
          m = be_merge({19'h0, col_q}, avs_writedata, avs_byteenable);
          col_d = m[12:0];
        end
        nand_host_pkg::OFF_ROW: begin
          m = be_merge({14'h0, row_q}, avs_writedata, avs_byteenable);
          row_d = m[17:0];
        end
        nand_host_pkg::OFF_STATUS: begin
          if (avs_byteenable[0] & avs_writedata[nand_host_pkg::STS_ERR_BIT]) err_d = 1'b0;
        end
        default: begin
        end
      endcase
    end
    // A refusal in the same cycle as a clear keeps the flag set
    if (state_q == S_IDLE & refuse) err_d = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      kind_q <= K_CMD;
      op_q <= OP_CMD;
      byte_q <= 8'h00;
      cnt_q <= 8'h00;
      idx_q <= 3'h0;
      last_q <= 3'h0;
      step_q <= 2'h0;
      wait_q <= 1'b0;
      ctrl_q <= nand_host_pkg::CTRL_RESET;
      col_q <= nand_host_pkg::COL_RESET;
      row_q <= nand_host_pkg::ROW_RESET;
      cmd_q <= nand_host_pkg::CMD_READ_SETUP;
      data_q <= 8'h00;
      err_q <= 1'b0;
    end else begin
      state_q <= state_d;
      kind_q <= kind_d;
      op_q <= op_d;
      byte_q <= byte_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      last_q <= last_d;
      step_q <= step_d;
      wait_q <= wait_d;
      ctrl_q <= ctrl_d;
      col_q <= col_d;
      row_q <= row_d;
      cmd_q <= cmd_d;
      data_q <= data_d;
      err_q <= err_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  logic on_bus;
  assign on_bus = (state_q == S_SETUP) | (state_q == S_PULSE);
  assign stb_low = (kind_q == K_DOUT) ? 8'(nand_host_pkg::CYC_RD_LOW) :
                   8'(nand_host_pkg::CYC_WP);
  assign stb_high = (kind_q == K_DOUT) ? 8'(nand_host_pkg::CYC_REH) :
                    8'(nand_host_pkg::CYC_WH);

  // Strobes stay high outside a cycle, so waits never clock the device
  always_comb begin
    pins.ce_n = ctrl_q[nand_host_pkg::CTRL_DESEL_BIT] & (state_q == S_IDLE);
    pins.cle = on_bus & (kind_q == K_CMD);
    pins.ale = on_bus & (kind_q == K_ADDR);
    pins.we_n = (kind_q == K_DOUT) ? 1'b1 : stb_n;
    pins.output_strobe_n = (kind_q == K_DOUT) ? stb_n : 1'b1;
    pins.wp_n = ctrl_q[nand_host_pkg::CTRL_WP_BIT];
    pins.io_oe = on_bus & (kind_q != K_DOUT);
    pins.io_out = byte_q;
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    avs_readdata = 32'h0000_0000;
    unique case ({avs_address[4:2], 2'b00})
      nand_host_pkg::OFF_CTRL: avs_readdata = {30'h0, ctrl_q};
      nand_host_pkg::OFF_CMD: avs_readdata = {24'h0, cmd_q};
      nand_host_pkg::OFF_COL: avs_readdata = {19'h0, col_q};
      nand_host_pkg::OFF_ROW: avs_readdata = {14'h0, row_q};
      nand_host_pkg::OFF_DATA: avs_readdata = {24'h0, data_q};
      nand_host_pkg::OFF_STATUS: begin
        avs_readdata[nand_host_pkg::STS_READY_BIT] = rdy;
        avs_readdata[nand_host_pkg::STS_ERR_BIT] = err_q;
        avs_readdata[nand_host_pkg::STS_ENGINE_BIT] = (state_q != S_IDLE);
        avs_readdata[nand_host_pkg::STS_BYTE_LSB +: 8] = data_q;
      end
      default: avs_readdata = 32'h0000_0000;
    endcase
  end

endmodule : nand_host

// ==== tb/nand_host_assertions.sv ====
// Checker of pin and bus timing for the NAND host controller
`timescale 1ns/1ps
module nand_host_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire nand_host_pkg::pins_t pins,
  input wire logic [7:0] io_in,
  input wire logic busy_flag_n
);
  // ----------------------------------------------------------------
  // Pin relations, one clock domain
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_cmd_drive: assert property ($rose(pins.we_n) && pins.cle |-> pins.io_oe && !pins.ale)
    else $error("command cycle without driven bus");
  a_addr_drive: assert property ($rose(pins.we_n) && pins.ale |-> pins.io_oe && !pins.cle)
    else $error("address cycle without driven bus");
  a_we_pulse: assert property ($fell(pins.we_n) |-> !pins.we_n [*3] ##1 pins.we_n [*2])
    else $error("write strobe width wrong");
  a_rd_pulse: assert property ($fell(pins.output_strobe_n) |->
    !pins.output_strobe_n [*7] ##1 pins.output_strobe_n)
    else $error("read strobe width wrong");
  // Host must float the bus while the flash drives it
  a_read_float: assert property (!pins.output_strobe_n |->
    !pins.io_oe && !pins.cle && !pins.ale && pins.we_n)
    else $error("bus driven during data out");
  a_data_wp: assert property ($fell(pins.we_n) && !pins.cle && !pins.ale |-> pins.wp_n)
    else $error("data input with write protect low");
  a_desel_idle: assert property (pins.ce_n |-> pins.we_n && pins.output_strobe_n)
    else $error("strobe while deselected");
  a_busy_quiet: assert property ($fell(pins.we_n) && !pins.cle |-> busy_flag_n)
    else $error("address or data cycle while busy");
endmodule : nand_host_assertions

bind nand_host nand_host_assertions chk (.clk(clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .pins(pins), .io_in(io_in), .busy_flag_n(busy_flag_n));

// ==== tb/nand_flash_model.sv ====
// Behavioural NAND flash device model facing the host controller
`timescale 1ns/1ps
module nand_flash_model #(
  parameter int BUSY_CYC = 200
) (
  input wire logic clk,
  input wire nand_host_pkg::pins_t pins,
  output logic [7:0] dout,
  output logic busy_flag_n
);
  logic [7:0] cmd_q = 8'h00;
  logic [7:0] ab [0:4];
  logic [7:0] mem [0:255];
  logic [7:0] last = 8'h00;
  logic [12:0] col;
  logic stat = 1'b0;
  logic standby;
  int na = 0;
  int bc = 0;
  // ----------------------------------------------------------------
  // Bus cycles latched on the write strobe rise
  // ----------------------------------------------------------------
  always @(posedge pins.we_n) begin
    if (!pins.ce_n && pins.cle && !pins.ale) begin
      // Codes outside the command set leave the model's state untouched
      if ((bc == 0 && pins.io_out inside {8'h00, 8'h05, 8'h10, 8'h11, 8'h15, 8'h30, 8'h31,
          8'h3A, 8'h3F, 8'h60, 8'h80, 8'h81, 8'h85, 8'h8C, 8'h90, 8'hD0, 8'hE0}) ||
          pins.io_out inside {8'h70, 8'h71, 8'hFF}) begin
        cmd_q = pins.io_out;
        stat = cmd_q inside {8'h70, 8'h71};
        na = 0;
        if (cmd_q inside {8'h30, 8'h31, 8'h3F, 8'h3A, 8'hFF}) bc = BUSY_CYC;
        // Whole-page program or whole-block erase; a final cached page adds its own busy
        if (pins.wp_n && cmd_q inside {8'h10, 8'h11, 8'h15, 8'hD0}) begin
          bc = BUSY_CYC;
        end
      end
    end else if (!pins.ce_n && pins.ale && na < 5) begin
      ab[na] = pins.io_out;
      na++;
      if (na < 3) col = {ab[1][4:0], ab[0]};
    end else if (!pins.ce_n && !pins.ale && pins.wp_n && bc == 0) begin
      mem[col[7:0]] = pins.io_out;
      col++;
    end
  end
  // Read strobe fall: status byte, or next byte with column advance
  always @(negedge pins.output_strobe_n) begin
    if (!pins.ce_n) begin
      // Status bit 0 is the pass/fail flag; this model never fails a page
      last = stat ? {1'b0, bc == 0, 6'h00} : mem[col[7:0]];
      if (!stat) col++;
    end
  end
  // Busy timer; the open-drain line is pulled high once released
  always @(posedge clk) begin
    if (bc > 0) bc--;
  end
  assign busy_flag_n = (bc == 0);
  assign standby = pins.ce_n && bc == 0;
  // Released bus shows the inverse, so a stale byte cannot pass
  assign dout = (!pins.ce_n && !pins.output_strobe_n) ? last : ~last;
endmodule : nand_flash_model

// ==== tb/nand_flash_command_interface_bench.sv ====
// Bench for the NAND host controller against a flash model
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module nand_flash_command_interface_bench;
  logic clk;
  logic rst_n;
  logic av_r;
  logic av_w;
  logic busy_n;
  logic [4:0] av_a;
  logic [31:0] av_d;
  logic [31:0] q;
  logic [7:0] dout;
  logic [7:0] io;
  logic [31:0] rdata;
  logic wt;
  logic [7:0] eab [0:4] = '{8'h05, 8'h10, 8'h41, 8'h40, 8'h02};
  nand_host_pkg::pins_t pins;
  int miscompares = 0;
  int comparisons = 0;
  int cyc = 0;
  // ----------------------------------------------------------------
  // Design, flash model and the shared bus wire
  // ----------------------------------------------------------------
  assign io = pins.io_oe ? pins.io_out : dout;
  nand_host dut (.clk(clk), .rst_n(rst_n), .avs_address(av_a), .avs_read(av_r),
    .avs_write(av_w), .avs_writedata(av_d), .avs_byteenable(4'hF), .avs_readdata(rdata),
    .avs_waitrequest(wt), .pins(pins), .io_in(io), .busy_flag_n(busy_n));
  nand_flash_model #(.BUSY_CYC(200)) fm (.clk(clk), .pins(pins), .dout(dout),
    .busy_flag_n(busy_n));
  // Clock and a hang guard well above the expected few thousand cycles
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic conclude();
    if (miscompares == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  // Avalon access: hold until waitrequest is sampled low
  task automatic acc(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    av_w <= wr;
    av_r <= !wr;
    av_a <= a;
    av_d <= d;
    do @(posedge clk); while (wt !== 1'b0);
    q = rdata;
    av_w <= 1'b0;
    av_r <= 1'b0;
  endtask : acc
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    av_r = 1'b0;
    av_w = 1'b0;
    av_a = 5'h00;
    av_d = 32'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    acc(0, nand_host_pkg::OFF_CMD, 0);
    `CHK("cmd", 8'h00, q[7:0])
    acc(0, nand_host_pkg::OFF_CTRL, 0);
    `CHK("ctrl", 2'h2, q[1:0])
    acc(1, nand_host_pkg::OFF_COL, 32'h1005);
    acc(1, nand_host_pkg::OFF_ROW, 32'h24041);
    acc(1, nand_host_pkg::OFF_CMD, 32'h80);
    acc(1, nand_host_pkg::OFF_DATA, 32'hA5);
    acc(0, nand_host_pkg::OFF_STATUS, 0);
    `CHK("wp err", 1'b1, q[1])
    acc(1, nand_host_pkg::OFF_STATUS, 32'h2);
    acc(1, nand_host_pkg::OFF_CTRL, 32'h1);
    acc(1, nand_host_pkg::OFF_CMD, 32'h80);
    acc(1, nand_host_pkg::OFF_ADDR, 0);
    for (int i = 0; i < 5; i++) `CHK("addr", eab[i], fm.ab[i])
    acc(1, nand_host_pkg::OFF_DATA, 32'hA5);
    acc(1, nand_host_pkg::OFF_DATA, 32'h3C);
    `CHK("mem", 16'h3CA5, {fm.mem[6], fm.mem[5]})
    acc(1, nand_host_pkg::OFF_CMD, 32'h110);
    `CHK("ready", 1'b1, busy_n)
    acc(1, nand_host_pkg::OFF_COL, 32'h1005);
    acc(1, nand_host_pkg::OFF_CMD, 32'h00);
    acc(1, nand_host_pkg::OFF_ADDR, 0);
    acc(1, nand_host_pkg::OFF_CMD, 32'h130);
    acc(0, nand_host_pkg::OFF_DATA, 0);
    `CHK("rd0", 8'hA5, q[7:0])
    acc(0, nand_host_pkg::OFF_DATA, 0);
    `CHK("rd1", 8'h3C, q[7:0])
    acc(0, nand_host_pkg::OFF_COL, 0);
    `CHK("col", 13'h1007, q[12:0])
    acc(1, nand_host_pkg::OFF_COL, 32'h1005);
    acc(1, nand_host_pkg::OFF_CMD, 32'h05);
    acc(1, nand_host_pkg::OFF_ADDR, 32'h1);
    acc(1, nand_host_pkg::OFF_CMD, 32'hE0);
    acc(0, nand_host_pkg::OFF_DATA, 0);
    `CHK("col change", 8'hA5, q[7:0])
    acc(1, nand_host_pkg::OFF_COL, 32'h10FF);
    acc(0, nand_host_pkg::OFF_DATA, 0);
    acc(0, nand_host_pkg::OFF_STATUS, 0);
    `CHK("last col", 2'h1, q[1:0])
    acc(0, nand_host_pkg::OFF_DATA, 0);
    acc(0, nand_host_pkg::OFF_STATUS, 0);
    `CHK("col limit", 1'b1, q[1])
    acc(1, nand_host_pkg::OFF_STATUS, 32'h2);
    acc(1, nand_host_pkg::OFF_CMD, 32'h10);
    acc(1, nand_host_pkg::OFF_CMD, 32'h00);
    acc(0, nand_host_pkg::OFF_STATUS, 0);
    `CHK("busy gate", 2'h2, q[1:0])
    `CHK("cmd hold", 8'h10, fm.cmd_q)
    acc(1, nand_host_pkg::OFF_FINISH, 0);
    `CHK("finish", 8'hFF, fm.cmd_q)
    `CHK("ready end", 1'b1, busy_n)
    acc(0, nand_host_pkg::OFF_STATUS, 0);
    `CHK("poll byte", 8'h40, q[15:8])
    acc(1, nand_host_pkg::OFF_CTRL, 32'h3);
    acc(0, nand_host_pkg::OFF_CTRL, 0);
    `CHK("ctrl set", 2'h3, q[1:0])
    `CHK("standby", 1'b1, fm.standby)
    conclude();
  end
endmodule : nand_flash_command_interface_bench
